// ---- rtl/adclp_dev.sv ----
// Converter end: serial port, threshold registers and alert logic
//
// What this block does
// - Lower threshold is nine bits then 000
// - Upper threshold is nine bits then 111
// - Deadband is 000 then nine bits
// - Deadband decides when an alert clears
// - Threshold register bits 15 to 9 read as zero
// - Reset lower zero, upper and deadband 0x1FF
// - Output driven only while chip select low
// - Works with clock idle low or high
// - Clock edges ignored while deselected
// - Start falling edge samples, converts 600 ns
// - Host raises start before conversion ends
// - MSB at select fall, shift on falling
// - Last bit launched 15th falling edge after first rising
// - Host samples on the rising clock edge
// - Host waits 1 us before next start
// - Write frame: address, bit10 one, data
// - Read frame answered in next frame
// - New conversion overrides pending read
// - Alert when result outside thresholds
// - Non-sticky alert clears past deadband
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module adclp_dev
   import adclp_pkg::*;
(
   // Clock and reset
   input  wire logic                pclk,
   input  wire logic                presetn,
   // Serial link
   adclp_if.dev                     link,
   // Converter side
   input  wire logic [ADC_W-1:0]    sample_in,
   input  wire logic [2:0]          conv_channel,
   input  wire logic                alert_sticky,
   // Status
   output logic                     conv_busy,
   output logic [2*NUM_CH-1:0]      alert_flags,
   output logic                     alert_any
);

   logic [3:0]               sync1_r;
   logic [3:0]               sync2_r;
   logic [3:0]               last_r;
   logic                     selected;
   logic                     cs_fall;
   logic                     cs_rise;
   logic                     sclk_rise;
   logic                     sclk_fall;
   logic                     conv_fall;
   logic [CNT_W-1:0]         conv_cnt_r;
   logic                     conv_done;
   logic [ADC_W-1:0]         held_r;
   logic [2:0]               held_ch_r;
   logic [FRAME_BITS-1:0]    result_r;
   logic                     conv_new_r;
   logic [FIELD_W-1:0]       lower_r [NUM_CH];
   logic [FIELD_W-1:0]       upper_r [NUM_CH];
   logic [FIELD_W-1:0]       deadband_r [NUM_CH];
   logic [2*NUM_CH-1:0]      alert_nxt;
   logic [FRAME_BITS-1:0]    rx_r;
   logic [FRAME_BITS-1:0]    tx_r;
   logic [BITCNT_W-1:0]      bit_cnt_r;
   logic                     seen_rise_r;
   logic                     rd_pend_r;
   logic [4:0]               rd_addr_r;
   logic                     frame_ok;
   logic [1:0]               rx_kind;
   logic [2:0]               rx_chan;

   // Pin synchronisers and edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 4'h9;
         sync2_r <= 4'h9;
         last_r  <= 4'h9;
      end else begin
         sync1_r <= {link.conversion_start_n_n, link.sdi, link.sclk, link.cs_n};
         sync2_r <= sync1_r;
         last_r  <= sync2_r;
      end
   end

   assign selected  = ~sync2_r[PIN_CS] & ~last_r[PIN_CS];
   assign cs_fall   = last_r[PIN_CS] & ~sync2_r[PIN_CS];
   assign cs_rise   = ~last_r[PIN_CS] & sync2_r[PIN_CS];
   assign sclk_rise = selected & ~last_r[PIN_SCLK] & sync2_r[PIN_SCLK];
   assign sclk_fall = selected & last_r[PIN_SCLK] & ~sync2_r[PIN_SCLK];
   assign conv_fall = last_r[PIN_CONV] & ~sync2_r[PIN_CONV];
   assign conv_done = conv_busy & (conv_cnt_r == 8'h01);

   // Conversion timer and sample hold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_busy  <= 1'b0;
         conv_cnt_r <= 8'h00;
         held_r     <= 12'h000;
         held_ch_r  <= 3'h0;
      end else if (conv_fall && !conv_busy) begin
         conv_busy  <= 1'b1;
         conv_cnt_r <= CNT_W'(CONV_CYC);
         held_r     <= sample_in;
         held_ch_r  <= conv_channel;
      end else if (conv_busy) begin
         conv_cnt_r <= conv_cnt_r - 8'h01;
         if (conv_done) begin
            conv_busy <= 1'b0;
         end
      end
   end

   // Limit comparison with deadband release
   always_comb begin
      logic [ADC_W:0] lo_th;
      logic [ADC_W:0] hi_th;
      logic [ADC_W:0] band;
      logic [ADC_W:0] smp;
      lo_th = 13'h0000;
      hi_th = 13'h0000;
      band  = 13'h0000;
      smp   = {1'b0, held_r};
      alert_nxt = alert_flags;
      for (int c = 0; c < NUM_CH; c++) begin
         lo_th = {1'b0, lower_r[c], 3'b000};
         hi_th = {1'b0, upper_r[c], 3'b111};
         band  = {4'h0, deadband_r[c]};
         if (conv_done && held_ch_r == 3'(c)) begin
            if (smp > hi_th) begin
               alert_nxt[2*c] = 1'b1;
            end else if (!alert_sticky && (smp + band < hi_th)) begin
               alert_nxt[2*c] = 1'b0;
            end
            if (smp < lo_th) begin
               alert_nxt[2*c+1] = 1'b1;
            end else if (!alert_sticky && (smp > lo_th + band)) begin
               alert_nxt[2*c+1] = 1'b0;
            end
         end
      end
   end

   // Alert flags and result word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alert_flags <= 8'h00;
         alert_any   <= 1'b0;
         result_r    <= 16'h0000;
      end else begin
         alert_flags <= alert_nxt;
         alert_any   <= |alert_nxt;
         if (conv_done) begin
            result_r <= {held_ch_r, |alert_nxt, held_r};
         end
      end
   end

   // New result flag; a completing conversion wins over the frame clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_new_r <= 1'b0;
      end else if (conv_done) begin
         conv_new_r <= 1'b1;
      end else if (cs_fall) begin
         conv_new_r <= 1'b0;
      end
   end

   assign frame_ok = cs_rise && (bit_cnt_r == 5'h10);
   assign rx_kind  = rx_r[ADDR_HI:KIND_LO];
   assign rx_chan  = rx_r[CHAN_HI:ADDR_LO];

   // Threshold register file
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < NUM_CH; c++) begin
            lower_r[c]    <= LOWER_RST;
            upper_r[c]    <= UPPER_RST;
            deadband_r[c] <= DEADBAND_RST;
         end
      end else if (frame_ok && rx_r[WR_BIT]) begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (rx_chan == 3'(c)) begin
               case (rx_kind)
                  KIND_LOWER:    lower_r[c]    <= rx_r[FIELD_W-1:0];
                  KIND_UPPER:    upper_r[c]    <= rx_r[FIELD_W-1:0];
                  KIND_DEADBAND: deadband_r[c] <= rx_r[FIELD_W-1:0];
                  default: ;
               endcase
            end
         end
      end
   end

   // Register read word
   function automatic logic [FRAME_BITS-1:0] read_word(input logic [4:0] a);
      logic [FIELD_W-1:0] f;
      f = 9'h000;
      read_word = 16'h0000;
      for (int c = 0; c < NUM_CH; c++) begin
         if (a[2:0] == 3'(c)) begin
            case (a[4:3])
               KIND_LOWER:    f = lower_r[c];
               KIND_UPPER:    f = upper_r[c];
               KIND_DEADBAND: f = deadband_r[c];
               default:       f = 9'h000;
            endcase
         end
      end
      if (a == RESULT_ADDR) begin
         read_word = result_r;
      end else begin
         read_word = {7'h00, f};
      end
   endfunction

   // Pending register read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_pend_r <= 1'b0;
         rd_addr_r <= 5'h00;
      end else if (frame_ok && !rx_r[WR_BIT]) begin
         rd_pend_r <= 1'b1;
         rd_addr_r <= rx_r[ADDR_HI:ADDR_LO];
      end else if (cs_fall) begin
         rd_pend_r <= 1'b0;
      end
   end

   // Frame shifter: capture on rising, launch on falling after a rising
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_r        <= 16'h0000;
         tx_r        <= 16'h0000;
         bit_cnt_r   <= 5'h00;
         seen_rise_r <= 1'b0;
      end else if (cs_fall) begin
         bit_cnt_r   <= 5'h00;
         seen_rise_r <= 1'b0;
         if (conv_new_r || !rd_pend_r) begin
            tx_r <= result_r;
         end else begin
            tx_r <= read_word(rd_addr_r);
         end
      end else if (sclk_rise) begin
         rx_r        <= {rx_r[FRAME_BITS-2:0], sync2_r[PIN_SDI]};
         seen_rise_r <= 1'b1;
         if (bit_cnt_r != 5'h10) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
         end
      end else if (sclk_fall && seen_rise_r) begin
         tx_r <= {tx_r[FRAME_BITS-2:0], 1'b0};
      end
   end

   // Serial output drive
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.sdo_o  <= 1'b0;
         link.sdo_oe <= 1'b0;
      end else begin
         link.sdo_o  <= tx_r[FRAME_BITS-1];
         link.sdo_oe <= ~sync2_r[PIN_CS];
      end
   end

endmodule // adclp_dev
`default_nettype wire

// ---- rtl/adclp_pkg.sv ----
// Shared constants for the converter serial port, both ends
package adclp_pkg;
   // Channels and word widths
   localparam int NUM_CH     = 4;
   localparam int ADC_W      = 12;
   localparam int FIELD_W    = 9;
   localparam int FRAME_BITS = 16;
   localparam int BITCNT_W   = 5;
   // Command frame fields
   localparam int ADDR_HI    = 15;
   localparam int KIND_LO    = 14;
   localparam int CHAN_HI    = 13;
   localparam int ADDR_LO    = 11;
   localparam int WR_BIT     = 10;
   // Register address kinds, address bits 4:3; channel in bits 2:0
   localparam logic [1:0] KIND_LOWER    = 2'h1;
   localparam logic [1:0] KIND_UPPER    = 2'h2;
   localparam logic [1:0] KIND_DEADBAND = 2'h3;
   localparam logic [4:0] RESULT_ADDR   = 5'h00;
   // Reset values of the threshold fields
   localparam logic [FIELD_W-1:0] LOWER_RST    = 9'h000;
   localparam logic [FIELD_W-1:0] UPPER_RST    = 9'h1FF;
   localparam logic [FIELD_W-1:0] DEADBAND_RST = 9'h1FF;
   // Result word layout
   localparam int RES_CH_LO = 13;
   localparam int RES_ALERT = 12;
   // Synchroniser bit positions
   localparam int PIN_CS   = 0;
   localparam int PIN_SCLK = 1;
   localparam int PIN_SDI  = 2;
   localparam int PIN_CONV = 3;
   // Timing
   localparam int CLK_NS          = 50;
   localparam int CONV_NS         = 600;
   localparam int CONV_CYC        = (CONV_NS + CLK_NS - 1) / CLK_NS;
   localparam int QUIET_NS        = 1000;
   localparam int QUIET_CYC       = (QUIET_NS + CLK_NS - 1) / CLK_NS;
   localparam int CONVERSION_START_N_LOW_CYC  = 4;
   localparam int CONV_MARGIN_CYC = 4;
   localparam int SCLK_HALF_CYC   = 10;
   localparam int SCLK_TOGGLES    = 2 * FRAME_BITS;
   localparam int CNT_W           = 8;
   // Host register map
   localparam logic [11:0] HOST_CTRL_ADDR = 12'h000;
   localparam logic [11:0] HOST_CMD_ADDR  = 12'h004;
   localparam logic [11:0] HOST_STAT_ADDR = 12'h008;
   localparam logic [11:0] HOST_RX_ADDR   = 12'h00C;
   localparam int CTRL_CONV  = 0;
   localparam int CTRL_FRAME = 1;
   localparam int CTRL_CPOL  = 2;
   localparam int STAT_BUSY  = 0;
endpackage

// ---- rtl/adclp_if.sv ----
// Serial link between converter and controller
`timescale 1ns/1ps
`default_nettype none
interface adclp_if;
   logic cs_n;
   logic sclk;
   logic sdi;
   logic conversion_start_n_n;
   logic sdo_o;
   logic sdo_oe;
   logic sdo;

   // Released line is pulled high
   assign sdo = sdo_oe ? sdo_o : 1'b1;

   modport dev  (input cs_n, sclk, sdi, conversion_start_n_n, output sdo_o, sdo_oe);
   modport host (output cs_n, sclk, sdi, conversion_start_n_n, input sdo);
endinterface
`default_nettype wire

// ---- rtl/adclp_host.sv ----
// Controller end: APB command registers driving the serial link
`timescale 1ns/1ps
`default_nettype none
module adclp_host
   import adclp_pkg::*;
(
   // Clock and reset
   input  wire logic          pclk,
   input  wire logic          presetn,
   // APB slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic               pready,
   output logic [31:0]        prdata,
   output logic               pslverr,
   // Serial link
   adclp_if.host              link
);

   typedef enum logic [2:0] {
      H_IDLE     = 3'b000,
      H_CONV_LOW = 3'b001,
      H_CONV_WAIT= 3'b010,
      H_CS_LEAD  = 3'b011,
      H_SHIFT    = 3'b100,
      H_CS_TAIL  = 3'b101,
      H_GAP      = 3'b110
   } adclp_hstate_type;

   adclp_hstate_type         state_r;
   logic [CNT_W-1:0]         cnt_r;
   logic [5:0]               tog_r;
   logic                     cpol_r;
   logic [FRAME_BITS-1:0]    cmd_r;
   logic [FRAME_BITS-1:0]    rx_r;
   logic [FRAME_BITS-1:0]    tx_r;
   logic                     seen_rise_r;
   logic                     sdo_s1_r;
   logic                     sdo_s2_r;
   logic                     access;
   logic                     wr_ctrl;
   logic                     mapped;

   assign access  = psel & penable & pready;
   assign wr_ctrl = access & pwrite & (paddr == HOST_CTRL_ADDR);
   assign mapped  = (paddr == HOST_CTRL_ADDR) | (paddr == HOST_CMD_ADDR) |
                    (paddr == HOST_STAT_ADDR) | (paddr == HOST_RX_ADDR);

   // APB answer: one access cycle, registered data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable && !pready) begin
         pready  <= 1'b1;
         pslverr <= ~mapped;
         case (paddr)
            HOST_CTRL_ADDR: prdata <= {29'h0, cpol_r, 2'b00};
            HOST_CMD_ADDR:  prdata <= {16'h0000, cmd_r};
            HOST_STAT_ADDR: prdata <= {31'h0, state_r != H_IDLE};
            HOST_RX_ADDR:   prdata <= {16'h0000, rx_r};
            default:        prdata <= 32'h0000_0000;
         endcase
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Software settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpol_r <= 1'b0;
         cmd_r  <= 16'h0000;
      end else if (access && pwrite) begin
         if (paddr == HOST_CTRL_ADDR && state_r == H_IDLE) begin
            cpol_r <= pwdata[CTRL_CPOL];
         end
         if (paddr == HOST_CMD_ADDR) begin
            cmd_r <= pwdata[FRAME_BITS-1:0];
         end
      end
   end

   // Returned data synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sdo_s1_r <= 1'b1;
         sdo_s2_r <= 1'b1;
      end else begin
         sdo_s1_r <= link.sdo;
         sdo_s2_r <= sdo_s1_r;
      end
   end

   // Conversion and frame sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r       <= H_IDLE;
         cnt_r         <= 8'h00;
         tog_r         <= 6'h00;
         tx_r          <= 16'h0000;
         rx_r          <= 16'h0000;
         seen_rise_r   <= 1'b0;
         link.cs_n     <= 1'b1;
         link.sclk     <= 1'b0;
         link.sdi      <= 1'b0;
         link.conversion_start_n_n <= 1'b1;
      end else begin
         case (state_r)
            H_IDLE: begin
               link.sclk <= cpol_r;
               if (wr_ctrl && pwdata[CTRL_CONV]) begin
                  link.conversion_start_n_n <= 1'b0;
                  cnt_r         <= CNT_W'(CONVERSION_START_N_LOW_CYC);
                  state_r       <= H_CONV_LOW;
               end else if (wr_ctrl && pwdata[CTRL_FRAME]) begin
                  cnt_r   <= 8'h01;
                  state_r <= H_CONV_WAIT;
               end
            end
            H_CONV_LOW: begin
               cnt_r <= cnt_r - 8'h01;
               if (cnt_r == 8'h01) begin
                  link.conversion_start_n_n <= 1'b1;
                  cnt_r <= CNT_W'(CONV_CYC + CONV_MARGIN_CYC - CONVERSION_START_N_LOW_CYC);
                  state_r <= H_CONV_WAIT;
               end
            end
            H_CONV_WAIT: begin
               cnt_r <= cnt_r - 8'h01;
               if (cnt_r == 8'h01) begin
                  link.cs_n   <= 1'b0;
                  link.sdi    <= cmd_r[FRAME_BITS-1];
                  tx_r        <= cmd_r;
                  seen_rise_r <= 1'b0;
                  tog_r       <= 6'h00;
                  cnt_r       <= CNT_W'(SCLK_HALF_CYC);
                  state_r     <= H_SHIFT;
               end
            end
            H_SHIFT: begin
               cnt_r <= cnt_r - 8'h01;
               if (cnt_r == 8'h01) begin
                  cnt_r     <= CNT_W'(SCLK_HALF_CYC);
                  link.sclk <= ~link.sclk;
                  tog_r     <= tog_r + 6'h01;
                  if (!link.sclk) begin
                     rx_r        <= {rx_r[FRAME_BITS-2:0], sdo_s2_r};
                     seen_rise_r <= 1'b1;
                  end else if (seen_rise_r) begin
                     tx_r     <= {tx_r[FRAME_BITS-2:0], 1'b0};
                     link.sdi <= tx_r[FRAME_BITS-2];
                  end
                  if (tog_r == 6'(SCLK_TOGGLES - 1)) begin
                     state_r <= H_CS_TAIL;
                  end
               end
            end
            H_CS_TAIL: begin
               cnt_r <= cnt_r - 8'h01;
               if (cnt_r == 8'h01) begin
                  link.cs_n <= 1'b1;
                  cnt_r     <= CNT_W'(QUIET_CYC);
                  state_r   <= H_GAP;
               end
            end
            H_GAP: begin
               cnt_r <= cnt_r - 8'h01;
               if (cnt_r == 8'h01) begin
                  state_r <= H_IDLE;
               end
            end
            default: state_r <= H_IDLE;
         endcase
      end
   end

endmodule // adclp_host
`default_nettype wire

// ---- testbench/adclp_link_assertions.sv ----
// Link-level assertions for the converter serial port
`timescale 1ns/1ps
`default_nettype none
module adclp_link_assertions (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Serial link
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic conversion_start_n_n,
   input wire logic sdo_o,
   input wire logic sdo_oe,
   input wire logic sdo
);
   logic       sclk_q;
   logic [5:0] tog_cnt;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Counts serial clock toggles inside a frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_q  <= 1'b0;
         tog_cnt <= 6'h00;
      end else begin
         sclk_q <= sclk;
         if (cs_n) begin
            tog_cnt <= 6'h00;
         end else if (sclk != sclk_q) begin
            tog_cnt <= tog_cnt + 6'h01;
         end
      end
   end

   property p_oe_idle;
      cs_n [*5] |-> !sdo_oe;
   endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("output driven while deselected");

   property p_oe_on;
      $fell(cs_n) |-> ##[2:4] sdo_oe;
   endproperty
   a_oe_on: assert property (p_oe_on)
      else $error("output not driven after select");

   property p_oe_sel;
      !cs_n [*5] |-> sdo_oe && sdo == sdo_o;
   endproperty
   a_oe_sel: assert property (p_oe_sel)
      else $error("output released inside frame");

   property p_oe_follows;
      sdo_oe |-> !$past(cs_n, 3);
   endproperty
   a_oe_follows: assert property (p_oe_follows)
      else $error("output driven without select");

   property p_start_pulse;
      $fell(conversion_start_n_n) |-> !conversion_start_n_n [*4] ##1 conversion_start_n_n;
   endproperty
   a_start_pulse: assert property (p_start_pulse)
      else $error("start pulse width wrong");

   property p_conv_wait;
      $fell(conversion_start_n_n) |-> cs_n [*8] ##1 cs_n [*7];
   endproperty
   a_conv_wait: assert property (p_conv_wait)
      else $error("frame began during conversion");

   property p_bit_hold;
      (!cs_n && $rose(sclk)) |-> $stable(sdo_o) [*8];
   endproperty
   a_bit_hold: assert property (p_bit_hold)
      else $error("output bit changed around rising edge");

   property p_edge_count;
      $rose(cs_n) |-> tog_cnt == 6'd32;
   endproperty
   a_edge_count: assert property (p_edge_count)
      else $error("frame ended without sixteen clocks");

   property p_gap;
      $rose(cs_n) |-> conversion_start_n_n [*8] ##1 conversion_start_n_n [*8] ##1 conversion_start_n_n [*4];
   endproperty
   a_gap: assert property (p_gap)
      else $error("next start too soon after frame");

   c_frame: cover property ($rose(cs_n) && tog_cnt == 6'd32);
   c_conv: cover property ($fell(conversion_start_n_n));
   c_idle_high: cover property (cs_n && sclk);
endmodule // adclp_link_assertions
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench: host and converter ends joined over the serial link
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import adclp_pkg::*;
   logic                pclk;
   logic                presetn;
   logic                psel;
   logic                penable;
   logic                pwrite;
   logic [11:0]         paddr;
   logic [31:0]         pwdata;
   logic                pready;
   logic [31:0]         prdata;
   logic                pslverr;
   logic [ADC_W-1:0]    sample_in;
   logic [2:0]          conv_channel;
   logic                alert_sticky;
   logic                conv_busy;
   logic [2*NUM_CH-1:0] alert_flags;
   logic                alert_any;
   logic [31:0]         rd;
   logic                rd_err;
   logic                cpol;
   int                  num_errors;
   int                  tests_run;
   int                  busy_cnt = 0;
   int                  busy_len = 0;

   adclp_if link_if ();
   adclp_host adclp_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .link(link_if));
   adclp_dev adclp_dev_i (.pclk(pclk), .presetn(presetn), .link(link_if),
      .sample_in(sample_in), .conv_channel(conv_channel), .alert_sticky(alert_sticky),
      .conv_busy(conv_busy), .alert_flags(alert_flags), .alert_any(alert_any));
   adclp_link_assertions adclp_link_assertions_i (.pclk(pclk), .presetn(presetn),
      .cs_n(link_if.cs_n), .sclk(link_if.sclk), .sdi(link_if.sdi),
      .conversion_start_n_n(link_if.conversion_start_n_n), .sdo_o(link_if.sdo_o), .sdo_oe(link_if.sdo_oe),
      .sdo(link_if.sdo));

   always #25 pclk = ~pclk;

   // Length of the latest busy period, cleared by each start pulse
   always @(posedge pclk) begin
      busy_cnt <= conv_busy ? busy_cnt + 1 : 0;
      if (!conv_busy && busy_cnt != 0) begin
         busy_len <= busy_cnt;
      end else if (!link_if.conversion_start_n_n) begin
         busy_len <= 0;
      end
   end

   task automatic report_and_stop;
      if (num_errors == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; read data and error taken at the ready edge
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
      int n;
      n = 0;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= addr;
      pwdata <= data;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge pclk);
      end
      if (pready !== 1'b1) begin
         num_errors++;
      end
      rd      = prdata;
      rd_err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // One serial frame, with or without a conversion in front
   task automatic frame(input logic [15:0] cmd, input logic conv);
      int n;
      n = 0;
      apb(1'b1, HOST_CMD_ADDR, {16'h0000, cmd});
      apb(1'b1, HOST_CTRL_ADDR, {29'h0, cpol, ~conv, conv});
      do begin
         apb(1'b0, HOST_STAT_ADDR, 32'h0);
         n++;
      end while (rd[STAT_BUSY] !== 1'b0 && n < 300);
      if (rd[STAT_BUSY] !== 1'b0) begin
         num_errors++;
      end
      apb(1'b0, HOST_RX_ADDR, 32'h0);
   endtask

   task automatic rdreg(input logic [4:0] a, input logic [15:0] exp);
      frame({a, 1'b0, 10'h000}, 1'b0);
      frame(16'h0000, 1'b0);
      check(rd, {16'h0000, exp});
   endtask

   task automatic conv(input logic [2:0] ch, input logic [11:0] s);
      @(posedge pclk);
      conv_channel <= ch;
      sample_in    <= s;
      frame(16'h0000, 1'b1);
      check(busy_len, CONV_CYC);
   endtask

   task automatic alert_step(input logic [2:0] ch, input logic [11:0] s, input logic st,
                             input logic [7:0] exp);
      alert_sticky <= st;
      conv(ch, s);
      check({24'h0, alert_flags}, {24'h0, exp});
      check({31'h0, alert_any}, {31'h0, |exp});
   endtask

   task automatic t_reset_values;
      for (int c = 0; c < NUM_CH; c++) begin
         rdreg(5'h08 + c[4:0], {7'h00, LOWER_RST});
         rdreg(5'h10 + c[4:0], {7'h00, UPPER_RST});
         rdreg(5'h18 + c[4:0], {7'h00, DEADBAND_RST});
      end
      check({31'h0, link_if.sdo_oe}, 32'h0);
   endtask

   task automatic t_write_read;
      frame({5'h11, 1'b1, 10'h3AB}, 1'b0);
      rdreg(5'h11, 16'h01AB);
      rdreg(5'h07, 16'h0000);
      apb(1'b1, 12'h010, 32'hFFFF_FFFF);
      check({31'h0, rd_err}, 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      check(rd, 32'h0);
   endtask

   task automatic t_convert;
      for (int p = 0; p < 2; p++) begin
         cpol = p[0];
         apb(1'b1, HOST_CTRL_ADDR, {29'h0, cpol, 2'b00});
         conv(3'd3, 12'hA5C);
         check(rd, {16'h0, 3'd3, 1'b0, 12'hA5C});
         rdreg(5'h11, 16'h01AB);
      end
   endtask

   task automatic t_override;
      frame({5'h11, 1'b0, 10'h000}, 1'b0);
      conv(3'd0, 12'h123);
      check(rd, {16'h0, 3'd0, 1'b0, 12'h123});
   endtask

   task automatic t_alerts;
      frame({5'h19, 1'b1, 10'h010}, 1'b0);
      frame({5'h0A, 1'b1, 10'h010}, 1'b0);
      alert_step(3'd1, 12'hD5F, 1'b0, 8'h00);
      alert_step(3'd1, 12'hD60, 1'b0, 8'h04);
      alert_step(3'd1, 12'hD50, 1'b0, 8'h04);
      alert_step(3'd1, 12'hD4E, 1'b0, 8'h00);
      alert_step(3'd2, 12'h080, 1'b0, 8'h00);
      alert_step(3'd2, 12'h07F, 1'b0, 8'h20);
      alert_step(3'd2, 12'h300, 1'b1, 8'h20);
      alert_step(3'd2, 12'h27F, 1'b0, 8'h20);
      alert_step(3'd2, 12'h280, 1'b0, 8'h00);
   endtask

   initial begin
      pclk         = 1'b0;
      presetn      = 1'b0;
      psel         = 1'b0;
      penable      = 1'b0;
      pwrite       = 1'b0;
      paddr        = 12'h000;
      pwdata       = 32'h0;
      sample_in    = 12'h000;
      conv_channel = 3'd0;
      alert_sticky = 1'b0;
      cpol         = 1'b0;
      num_errors   = 0;
      tests_run    = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_values;
      t_write_read;
      t_convert;
      t_override;
      t_alerts;
      report_and_stop;
   end

   // Watchdog against a hung handshake
   initial begin
      repeat (80000) @(posedge pclk);
      num_errors++;
      report_and_stop;
   end
endmodule // testbench
`default_nettype wire
